// File: inc/lcrm_regs.vh
// Constants for the link configuration and ranging command block
`ifndef LCRM_REGS_VH
`define LCRM_REGS_VH
`define LCRM_ADDR_W 48
`define LCRM_TAG_W 4
`define LCRM_RATE_W 3
`define LCRM_ACK_W 2
`define LCRM_RETRY_W 4
`define LCRM_SIZE_W 12
`define LCRM_CNT_W 8
`define LCRM_REC_W 16
`define LCRM_ACK_NONE 2'h0
`define LCRM_ACK_IMM 2'h1
`define LCRM_ACK_BLOCK 2'h2
`define LCRM_OUT_FAIL 1'h0
`define LCRM_OUT_OK 1'h1
`define LCRM_RETRY_CEIL 4'hF
`define LCRM_SIZE_MIN 12'h020
`define LCRM_SIZE_MAX 12'hFFF
`define LCRM_RES_DEPTH 255
`define LCRM_MEAS_TIMEOUT 16'h0FFF
`endif

// File: verification/lcrm_monitor.sv
// Port checker for the link configuration and ranging handler
`timescale 1ns/1ps
module lcrm_monitor (
  input wire clk, // Clock
  input wire reset, // Reset
  input wire cfg_req, // Cfg req
  input wire [1:0] cfg_ack_scheme, // Ack
  input wire [3:0] cfg_retry_limit, // Retry
  input wire cfg_cnf, // Cfg cnf
  input wire cfg_cnf_outcome_code, // Outcome
  input wire local_ranging_on, // Enable
  input wire rng_req, // Rng req
  input wire [47:0] rng_peer_address, // Peer
  input wire [7:0] measurement_count_req, // Count
  input wire rng_frame_tx, // Frame
  input wire rng_cnf, // Rng cnf
  input wire rng_cnf_outcome_code, // Outcome
  input wire peer_rng_cmd, // Peer frame
  input wire peer_rng_is_req, // Type
  input wire rng_ind // Ind
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Handler busy from an accepted request until its confirm
  reg busy_q;
  wire idle = !busy_q || rng_cnf;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      busy_q <= 1'b0;
    else if (rng_req && idle)
      busy_q <= 1'b1;
    else if (rng_cnf)
      busy_q <= 1'b0;
  end
  // Accepted unicast request with ranging on
  wire go = rng_req && idle && local_ranging_on && !rng_peer_address[40];
  a_cfg_cnf_next: assert property (cfg_req |=> cfg_cnf) else $error("no confirm");
  a_cnf_no_spur: assert property (!cfg_req |=> !cfg_cnf) else $error("stray confirm");
  a_bad_ack: assert property (cfg_req && cfg_ack_scheme == 2'h3 |=>
    !cfg_cnf_outcome_code) else $error("bad ack accepted");
  a_bad_retry: assert property (cfg_req && cfg_retry_limit == 4'h0 |=>
    !cfg_cnf_outcome_code) else $error("zero retry accepted");
  a_rng_off: assert property (rng_req && idle && !local_ranging_on |-> ##2
    rng_cnf && !rng_cnf_outcome_code) else $error("ranging while off");
  a_rng_frame: assert property (go && measurement_count_req != 8'h00 |->
    !rng_cnf [*2] ##1 rng_frame_tx) else $error("no frame");
  a_cnt_zero: assert property (go && measurement_count_req == 8'h00 |-> ##2
    rng_cnf && rng_cnf_outcome_code) else $error("zero count confirm");
  a_ind_req: assert property ($rose(peer_rng_cmd) && peer_rng_is_req |-> ##3
    rng_ind) else $error("no indication");
  c_cfg: cover property (cfg_cnf && cfg_cnf_outcome_code);
  c_rng: cover property (rng_cnf && rng_cnf_outcome_code);
  c_ind: cover property (rng_ind);
endmodule
bind lcrm_top lcrm_monitor i_mon (.*);

// File: verification/lcrm_peer_model.sv
// Far-end model answering ranging frames with result records
`timescale 1ns/1ps
module lcrm_peer_model (
  input wire clk, // Clock
  input wire reset, // Reset
  input wire stall, // Slow answers
  input wire rng_frame_tx, // Frame sent
  output reg rng_meas_done, // Result back
  output reg [15:0] rng_meas_record // Record
);
  reg [7:0] n_q;
  reg [3:0] t_q;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      n_q <= 8'h00;
      t_q <= 4'h0;
      rng_meas_done <= 1'b0;
      rng_meas_record <= 16'hFFFF;
    end
    else
    begin
      if (rng_frame_tx)
        t_q <= stall ? 4'hD : 4'h5;
      else if (t_q != 4'h0)
        t_q <= t_q - 4'h1;
      rng_meas_done <= t_q > 4'h1 && t_q < 4'h5;
      // Record toggles whenever no result is offered
      rng_meas_record <= (t_q > 4'h1 && t_q < 4'h5) ? {8'hC3, n_q} : ~rng_meas_record;
      if (t_q == 4'h1)
        n_q <= n_q + 8'h01;
    end
  end
endmodule

// File: verification/lcrm_top_bench.sv
// Testbench for the link configuration and ranging handler
`timescale 1ns/1ps
module lcrm_top_bench;
  localparam logic [47:0] uc_addr = 48'h0200000000AA;
  logic clk = 1'b0, reset = 1'b1, stall = 1'b0, local_ranging_on = 1'b1;
  logic cfg_req = 1'b0, cfg_merge_policy = 1'b0, cfg_split_policy = 1'b0;
  logic rng_req = 1'b0, peer_rng_cmd = 1'b0, peer_rng_is_req = 1'b0;
  logic [1:0] cfg_peer_slot = 2'h0, use_peer_slot = 2'h0, cfg_ack_scheme = 2'h0;
  logic [3:0] cfg_delivery_tag = 4'h0, use_delivery_tag = 4'h0, cfg_retry_limit = 4'h1;
  logic [2:0] cfg_tx_rate_select = 3'h0, use_tx_rate_select;
  logic [11:0] cfg_preferred_frame_size = 12'h020, use_preferred_frame_size;
  logic [47:0] cfg_peer_address = 48'h0, rng_peer_address = 48'h0;
  logic [7:0] measurement_count_req = 8'h0, res_rd_idx = 8'h0, ranging_result_count;
  logic cfg_cnf, cfg_cnf_outcome_code, use_is_stream, use_merge_en, use_split_en, rng_ind;
  logic rng_frame_tx, rng_meas_done, rng_cnf, rng_cnf_outcome_code;
  logic [47:0] cfg_cnf_peer_address, rng_frame_peer;
  logic [3:0] cfg_cnf_delivery_tag, use_retry_limit;
  logic [1:0] use_ack_scheme;
  logic [15:0] rng_meas_record, res_rd_data;
  logic [29:0] g;
  integer err_total = 0, n_compared = 0, nfr = 0, nexp = 0, cyc = 0, i;
  // Ok, slot, tag, rate, ack, retry, size, merge and split
  logic [29:0] rows [0:5] = '{{1'h1, 2'h1, 4'h3, 3'h0, 2'h0, 4'h1, 12'h020, 2'h2},
    {1'h0, 2'h1, 4'h3, 3'h1, 2'h3, 4'h2, 12'h030, 2'h1}, {1'h1, 2'h2, 4'h8, 3'h7, 2'h1, 4'hF,
    12'hFFF, 2'h1}, {1'h0, 2'h2, 4'h8, 3'h2, 2'h1, 4'h0, 12'h040, 2'h2}, {1'h1, 2'h3, 4'hF,
    3'h5, 2'h2, 4'h7, 12'h100, 2'h3}, {1'h0, 2'h3, 4'hF, 3'h4, 2'h2, 4'h7, 12'h01F, 2'h0}};
  lcrm_top #(.SLOTS(4), .MEAS_TIMEOUT(16'h0014)) i_dut (.*);
  lcrm_peer_model i_peer (.*);
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    nfr <= nfr + (rng_frame_tx === 1'b1);
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      conclude;
    end
  end
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Request r, then expect g held at the same connection
  task automatic cfg(input logic [29:0] r, input logic [29:0] e);
    @(posedge clk);
    cfg_req <= 1'b1;
    {cfg_peer_slot, cfg_delivery_tag, cfg_tx_rate_select, cfg_ack_scheme, cfg_retry_limit,
      cfg_preferred_frame_size, cfg_merge_policy, cfg_split_policy} <= r[28:0];
    {use_peer_slot, use_delivery_tag} <= r[28:23];
    cfg_peer_address <= {42'h2A5, r[28:23]};
    @(posedge clk);
    cfg_req <= 1'b0;
    #1 check({cfg_cnf, cfg_cnf_outcome_code, cfg_cnf_delivery_tag, cfg_cnf_peer_address},
      {1'h1, r[29], r[26:23], 42'h2A5, r[28:23]});
    repeat (2) @(posedge clk);
    #1 check({use_is_stream, use_tx_rate_select, use_ack_scheme, use_retry_limit,
      use_preferred_frame_size, use_merge_en, use_split_en}, {e[26], e[22:0]});
  endtask
  task automatic rng(input logic [47:0] a, input logic [7:0] n, input logic ok,
    input logic [7:0] c, input integer f);
    integer k;
    @(posedge clk);
    rng_req <= 1'b1;
    rng_peer_address <= a;
    measurement_count_req <= n;
    @(posedge clk);
    rng_req <= 1'b0;
    for (k = 0; k < 600 && rng_cnf !== 1'b1; k++)
      @(posedge clk) #1;
    nexp = nexp + f;
    check({rng_cnf, rng_cnf_outcome_code, ranging_result_count}, {1'h1, ok, c});
    check(nfr, nexp);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    @(posedge clk);
    res_rd_idx <= idx;
    repeat (2) @(posedge clk);
    #1 check(res_rd_data, e);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    check({cfg_cnf, rng_cnf, rng_ind, rng_frame_tx, ranging_result_count}, 0);
    reset <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      if (rows[i][29])
        g = rows[i];
      cfg(rows[i], g);
    end
    for (i = 0; i < 8; i++)
    begin
      g = {1'h1, 2'h0, i[0], i[2:0], i[2:0], 2'(i % 3), 4'h3, 12'h040, 2'h1};
      cfg(g, g);
    end
    rng(uc_addr, 8'h03, 1'h1, 8'h03, 3);
    for (i = 0; i < 3; i++)
      rd(i[7:0], {8'hC3, i[7:0]});
    stall <= 1'b1;
    rng(uc_addr, 8'h01, 1'h1, 8'h01, 1);
    check(rng_frame_peer, uc_addr);
    rd(8'h00, 16'hC303);
    rd(8'hFF, 16'h0000);
    stall <= 1'b0;
    rng(48'h0300000000AA, 8'h02, 1'h0, 8'h00, 0);
    rng(uc_addr, 8'h00, 1'h1, 8'h00, 0);
    @(posedge clk);
    local_ranging_on <= 1'b0;
    rng(uc_addr, 8'h02, 1'h0, 8'h00, 0);
    @(posedge clk);
    local_ranging_on <= 1'b1;
    fork
      rng(uc_addr, 8'h02, 1'h0, 8'h00, 1);
      begin
        repeat (4) @(posedge clk);
        local_ranging_on <= 1'b0;
      end
    join
    @(posedge clk);
    peer_rng_is_req <= 1'b1;
    peer_rng_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(rng_ind, 1'b1);
    @(posedge clk);
    peer_rng_cmd <= 1'b0;
    peer_rng_is_req <= 1'b0;
    repeat (3) @(posedge clk);
    peer_rng_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(rng_ind, 1'b0);
    // Mid-run reset clears the table and the confirm state
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({use_tx_rate_select, use_ack_scheme, use_retry_limit, use_merge_en,
      cfg_cnf_outcome_code, ranging_result_count, rng_cnf}, 0);
    conclude;
  end
endmodule

// File: verilog/lcrm_conn_table.v
// Per-connection settings store, indexed by peer slot and delivery tag
`timescale 1ns/1ps
`include "lcrm_regs.vh"
module lcrm_conn_table #(
  parameter SLOTS = 4
)
(
  input wire clk, // Clock
  input wire reset, // Async reset, active high
  input wire wr_en, // Write whole entry
  input wire [5:0] wr_idx, // Entry written
  input wire [25:0] wr_data, // Packed settings
  input wire [5:0] rd_idx, // Entry read
  output wire [25:0] rd_data // Packed settings of rd_idx
);
  localparam N = SLOTS * 16;
  reg [25:0] mem_q [0:N-1];
  integer i;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (i = 0; i < N; i = i + 1)
        mem_q[i] <= 26'h0;
    end
    else if (wr_en)
    begin
      mem_q[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem_q[rd_idx];
endmodule

// File: verilog/lcrm_top.v
// Connection configuration and range measurement command handler
`timescale 1ns/1ps
`include "lcrm_regs.vh"
//
// Overview of operation
// - Valid config request overwrites selected connection, then confirms
// - Confirm echoes address, tag, success or failure
// - Tag 0-7 priority, 8-15 stream index
// - Rate selects one of eight rates
// - Ack scheme none, immediate or block
// - Retry limit 1 to ceiling, never exceeded
// - Separate merge and split enable flags
// - Store preferred frame size per connection
// - Ranging request: unicast peer, 8-bit count
// - Send ranging frames, then deliver results
// - Peer ranging request raises indication
// - Confirm gives outcome, result list, count
// - Local ranging only while enable true
// - Addresses are 48-bit, ranging ones unicast
module lcrm_top #(
  parameter SLOTS = 4,
  parameter [15:0] MEAS_TIMEOUT = `LCRM_MEAS_TIMEOUT
)
(
  input wire clk, // 20 MHz clock
  input wire reset, // Async reset, active high
  input wire cfg_req, // Config request pulse
  input wire [47:0] cfg_peer_address, // Connection peer
  input wire [1:0] cfg_peer_slot, // Table slot of the peer
  input wire [3:0] cfg_delivery_tag, // Priority or stream
  input wire [2:0] cfg_tx_rate_select, // Rate code
  input wire [1:0] cfg_ack_scheme, // Ack mode
  input wire [3:0] cfg_retry_limit, // Retransmissions
  input wire [11:0] cfg_preferred_frame_size, // Frame size
  input wire cfg_merge_policy, // Aggregation enable
  input wire cfg_split_policy, // Fragmentation enable
  output reg cfg_cnf, // Config confirm pulse
  output reg [47:0] cfg_cnf_peer_address, // Echoed peer
  output reg [3:0] cfg_cnf_delivery_tag, // Echoed tag
  output reg cfg_cnf_outcome_code, // 1 success, 0 failure
  input wire [1:0] use_peer_slot, // Lookup slot for transmit path
  input wire [3:0] use_delivery_tag, // Lookup tag for transmit path
  output reg use_is_stream, // Tag is a stream index
  output reg [2:0] use_tx_rate_select, // Rate for this packet
  output reg [1:0] use_ack_scheme, // Ack mode for this packet
  output reg [3:0] use_retry_limit, // Retry bound
  output reg [11:0] use_preferred_frame_size, // Frame size
  output reg use_merge_en, // Aggregation allowed
  output reg use_split_en, // Fragmentation allowed
  input wire local_ranging_on, // Local ranging enable
  input wire rng_req, // Ranging request pulse
  input wire [47:0] rng_peer_address, // Ranging peer
  input wire [7:0] measurement_count_req, // Measurements wanted
  output reg rng_frame_tx, // Send one ranging frame
  output reg [47:0] rng_frame_peer, // Frame destination
  input wire rng_meas_done, // Measurement returned (async)
  input wire [15:0] rng_meas_record, // Result record
  output reg rng_cnf, // Ranging confirm pulse
  output reg rng_cnf_outcome_code, // 1 success, 0 failure
  output reg [7:0] ranging_result_count, // Results held
  input wire [7:0] res_rd_idx, // Result list read index
  output reg [15:0] res_rd_data, // Result list entry
  input wire peer_rng_cmd, // Peer ranging frame seen (async)
  input wire peer_rng_is_req, // Range type is request
  output reg rng_ind // Ranging indication pulse
);
  localparam S_IDLE = 4'h1;
  localparam S_SEND = 4'h2;
  localparam S_WAIT = 4'h4;
  localparam S_DONE = 4'h8;

  function is_unicast;
    input [47:0] a;
    begin
      is_unicast = ~a[40];
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [2:0] done_s_q, peer_s_q;
  reg [1:0] type_s_q;
  reg [15:0] rec_s1_q, rec_s2_q;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      done_s_q <= 3'h0;
      peer_s_q <= 3'h0;
      type_s_q <= 2'h0;
      rec_s1_q <= 16'h0;
      rec_s2_q <= 16'h0;
    end
    else
    begin
      done_s_q <= {done_s_q[1:0], rng_meas_done};
      peer_s_q <= {peer_s_q[1:0], peer_rng_cmd};
      type_s_q <= {type_s_q[0], peer_rng_is_req};
      // Record follows the same two stages as its strobe
      rec_s1_q <= rng_meas_record;
      rec_s2_q <= rec_s1_q;
    end
  end
  wire done_ev = done_s_q[1] & ~done_s_q[2];
  wire peer_ev = peer_s_q[1] & ~peer_s_q[2];

  // ----------------------------------------
  // Connection configuration
  // ----------------------------------------
  wire [25:0] rd_data;
  wire ack_ok = (cfg_ack_scheme == `LCRM_ACK_NONE) | (cfg_ack_scheme == `LCRM_ACK_IMM) |
    (cfg_ack_scheme == `LCRM_ACK_BLOCK);
  wire retry_ok = (cfg_retry_limit != 4'h0) && (cfg_retry_limit <= `LCRM_RETRY_CEIL);
  wire size_ok = (cfg_preferred_frame_size >= `LCRM_SIZE_MIN) &&
    (cfg_preferred_frame_size <= `LCRM_SIZE_MAX);
  wire cfg_ok = ack_ok & retry_ok & size_ok;
  wire [25:0] wr_data = {cfg_tx_rate_select, cfg_ack_scheme, cfg_retry_limit,
    cfg_preferred_frame_size, cfg_merge_policy, cfg_split_policy, 1'h1, 2'h0};

  lcrm_conn_table #(.SLOTS(SLOTS)) u_table (
    .clk(clk),
    .reset(reset),
    .wr_en(cfg_req & cfg_ok),
    .wr_idx({cfg_peer_slot, cfg_delivery_tag}),
    .wr_data(wr_data),
    .rd_idx({use_peer_slot, use_delivery_tag}),
    .rd_data(rd_data)
  );

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_cnf <= 1'h0;
      cfg_cnf_peer_address <= 48'h0;
      cfg_cnf_delivery_tag <= 4'h0;
      cfg_cnf_outcome_code <= `LCRM_OUT_FAIL;
      use_is_stream <= 1'h0;
      use_tx_rate_select <= 3'h0;
      use_ack_scheme <= 2'h0;
      use_retry_limit <= 4'h0;
      use_preferred_frame_size <= 12'h0;
      use_merge_en <= 1'h0;
      use_split_en <= 1'h0;
    end
    else
    begin
      cfg_cnf <= cfg_req;
      if (cfg_req)
      begin
        cfg_cnf_peer_address <= cfg_peer_address;
        cfg_cnf_delivery_tag <= cfg_delivery_tag;
        cfg_cnf_outcome_code <= cfg_ok ? `LCRM_OUT_OK : `LCRM_OUT_FAIL;
      end
      use_is_stream <= use_delivery_tag[3];
      use_tx_rate_select <= rd_data[25:23];
      use_ack_scheme <= rd_data[22:21];
      use_retry_limit <= rd_data[20:17];
      use_preferred_frame_size <= rd_data[16:5];
      use_merge_en <= rd_data[4] & rd_data[2];
      use_split_en <= rd_data[3] & rd_data[2];
    end
  end

  // ----------------------------------------
  // Range measurement
  // ----------------------------------------
  reg [3:0] st_q;
  reg [7:0] left_q;
  reg [15:0] tmo_q;
  reg ok_q;
  reg [15:0] res_q [0:`LCRM_RES_DEPTH-1];
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= S_IDLE;
      left_q <= 8'h0;
      tmo_q <= 16'h0;
      ok_q <= 1'h0;
      rng_frame_tx <= 1'h0;
      rng_frame_peer <= 48'h0;
      rng_cnf <= 1'h0;
      rng_cnf_outcome_code <= `LCRM_OUT_FAIL;
      ranging_result_count <= 8'h0;
      rng_ind <= 1'h0;
      res_rd_data <= 16'h0;
    end
    else
    begin
      rng_frame_tx <= 1'h0;
      rng_cnf <= 1'h0;
      rng_ind <= peer_ev & type_s_q[1];
      res_rd_data <= (res_rd_idx < 8'hFF) ? res_q[res_rd_idx] : 16'h0;
      case (st_q)
        S_IDLE:
        begin
          if (rng_req)
          begin
            rng_frame_peer <= rng_peer_address;
            ranging_result_count <= 8'h0;
            left_q <= measurement_count_req;
            ok_q <= local_ranging_on & is_unicast(rng_peer_address);
            if (local_ranging_on && is_unicast(rng_peer_address) &&
                measurement_count_req != 8'h0)
              st_q <= S_SEND;
            else
              st_q <= S_DONE;
          end
        end
        S_SEND:
        begin
          rng_frame_tx <= 1'h1;
          tmo_q <= MEAS_TIMEOUT;
          st_q <= S_WAIT;
        end
        S_WAIT:
        begin
          if (!local_ranging_on || tmo_q == 16'h0)
          begin
            ok_q <= 1'h0;
            st_q <= S_DONE;
          end
          else if (done_ev)
          begin
            ranging_result_count <= ranging_result_count + 8'h01;
            left_q <= left_q - 8'h01;
            st_q <= (left_q == 8'h01) ? S_DONE : S_SEND;
          end
          else
            tmo_q <= tmo_q - 16'h0001;
        end
        S_DONE:
        begin
          rng_cnf <= 1'h1;
          rng_cnf_outcome_code <= ok_q ? `LCRM_OUT_OK : `LCRM_OUT_FAIL;
          st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // Result records, no reset needed on the data
  always @(posedge clk)
  begin
    if (st_q == S_WAIT && done_ev && local_ranging_on && tmo_q != 16'h0 &&
        ranging_result_count < 8'hFF)
      res_q[ranging_result_count] <= rec_s2_q;
  end
endmodule
